// ===== logic/dcw_decode.sv
// Control word decoder: software register, boost control, watchdog
// How it works
// - Codes 100/101/110 select current ranges
// - Codes 010/011 select bipolar voltage ranges
// - Header 100 marks software register write
// - Code 0x555 resets toggle, boost and watchdog; switching divider keeps running
// - Toggle bit 12 copied into status_toggle
// - Missed service raises fault alert
// - Disabled watchdog never raises fault
// - Header 011 marks boost write, ignores 12:7
// - Bits 6, 5:4, 3:2 are comp/phase/freq
// - Bits 1:0 limit boost voltage
// - Phase field sets per-channel switching edges
// - Switching clock divided from 13 MHz oscillator
`timescale 1ns/100ps
`default_nettype none
module dcw_decode
  import dcw_pkg::*;
#(
  parameter int WDT_CYCLES = WDT_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        osc_clk,
  input  wire logic        word_valid,
  input  wire logic [15:0] word_data,
  input  wire logic [2:0]  output_range_select,
  input  wire logic        wdt_enable,
  output dcw_range_t       range_decoded,
  output logic             status_toggle,
  output dcw_boost_t       boost_cfg,
  output logic             fault_alert,
  output logic [3:0]       boost_switch_clk,
  output logic             soft_reset
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] half_period(input logic [1:0] f);
    unique case (f)
      2'h0:    half_period = 6'(DIV_250K - 1);
      2'h1:    half_period = 6'(DIV_410K - 1);
      default: half_period = 6'(DIV_650K - 1);
    endcase
  endfunction : half_period

  always_comb begin
    unique case (output_range_select)
      3'h0:    range_decoded = DCW_V0_5;
      3'h1:    range_decoded = DCW_V0_10;
      3'h2:    range_decoded = DCW_VPM5;
      3'h3:    range_decoded = DCW_VPM10;
      3'h4:    range_decoded = DCW_I4_20;
      3'h5:    range_decoded = DCW_I0_20;
      3'h6:    range_decoded = DCW_I0_24;
      default: range_decoded = DCW_INVALID;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Word and watchdog logic in clk domain; the word is synchronous to clk
  dcw_state_t state;
  dcw_state_t next_state;
  logic       sw_write;
  logic       boost_write;
  logic       reset_hit;
  logic       service_hit;
  logic       wdt_en_s1;
  logic       wdt_en;

  assign sw_write    = word_valid && word_data[15:ID_POS] == SW_ID;
  assign boost_write = word_valid
                       && word_data[15:ID_POS] == BOOST_ID;
  assign reset_hit   = sw_write && word_data[11:0] == RESET_CODE;
  assign service_hit = sw_write && word_data[11:0] == SERVICE_CODE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_en_s1 <= 1'b0;
      wdt_en    <= 1'b0;
    end else begin
      wdt_en_s1 <= wdt_enable;
      wdt_en    <= wdt_en_s1;
    end
  end

  always_comb begin
    next_state = state;
    if (reset_hit) begin
      next_state = '0;
      next_state.boost.freq = FREQ_RST;
    end else begin
      if (sw_write)
        next_state.toggle = word_data[TOGGLE_POS];
      if (boost_write) begin
        next_state.boost.comp  = word_data[COMP_POS];
        next_state.boost.phase = word_data[PHASE_POS +: 2];
        next_state.boost.freq  = word_data[FREQ_POS +: 2];
        next_state.boost.vlim  = word_data[VLIM_POS +: 2];
      end
      if (!wdt_en) begin
        next_state.wdt_cnt = '0;
        next_state.fault   = 1'b0;
      end else if (service_hit) begin
        next_state.wdt_cnt = '0;
      end else if (state.wdt_cnt >= 32'(WDT_CYCLES - 1)) begin
        next_state.fault = 1'b1;
      end else begin
        next_state.wdt_cnt = state.wdt_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state            <= '0;
      state.boost.freq <= FREQ_RST;
    end else begin
      state.boost   <= next_state.boost;
      state.toggle  <= next_state.toggle;
      state.wdt_cnt <= next_state.wdt_cnt;
      state.fault   <= next_state.fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Switching clock on the oscillator; settings cross via two flops
  // Settings word taken only once two synced samples agree
  dcw_boost_t osc_cfg_s1;
  dcw_boost_t osc_cfg_s2;
  dcw_boost_t osc_cfg;
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic [3:0] phase_clk;
  logic [3:0] next_phase_clk;
  logic       tick;

  always_ff @(posedge osc_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cfg_s1 <= '0;
      osc_cfg_s2 <= '0;
      osc_cfg    <= '0;
      div_cnt    <= '0;
      phase_clk  <= '0;
    end else begin
      osc_cfg_s1 <= state.boost;
      osc_cfg_s2 <= osc_cfg_s1;
      if (osc_cfg_s1 == osc_cfg_s2)
        osc_cfg <= osc_cfg_s2;
      div_cnt    <= next_div_cnt;
      phase_clk  <= next_phase_clk;
    end
  end

  always_comb begin
    tick = div_cnt >= half_period(osc_cfg.freq);
    next_div_cnt = tick ? 6'h0 : div_cnt + 6'h1;
    next_phase_clk = phase_clk;
    if (tick)
      next_phase_clk = phase_clk + 4'h1;
  end

  always_comb begin
    unique case (osc_cfg.phase)
      2'h0: boost_switch_clk = {4{phase_clk[0]}};
      2'h1: boost_switch_clk = {~phase_clk[0], ~phase_clk[0],
                                phase_clk[0], phase_clk[0]};
      2'h2: boost_switch_clk = {~phase_clk[0], phase_clk[0],
                                ~phase_clk[0], phase_clk[0]};
      2'h3: boost_switch_clk = {phase_clk[2] ^ phase_clk[1],
                                ~phase_clk[2],
                                phase_clk[2] ^ ~phase_clk[1],
                                phase_clk[2]};
    endcase
  end

  assign status_toggle = state.toggle;
  assign boost_cfg     = state.boost;
  assign fault_alert   = state.fault;
  assign soft_reset    = reset_hit;

  ////////////////////////////////////////////////////////////////////////
  chk_toggle_copy: assert property (@(posedge clk) disable iff (!rst_b)
    sw_write && !reset_hit |=> status_toggle == $past(word_data[12]))
    else $error("toggle bit not copied");
  chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_b)
    reset_hit |=> !status_toggle && !fault_alert && boost_cfg.freq == 2'h1)
    else $error("reset code did not reset");
  chk_boost_load: assert property (@(posedge clk) disable iff (!rst_b)
    boost_write |=> boost_cfg == $past(word_data[6:0]))
    else $error("boost fields not loaded");
  chk_boost_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !boost_write && !reset_hit |=> $stable(boost_cfg))
    else $error("boost changed without write");
  chk_wdt_off: assert property (@(posedge clk) disable iff (!rst_b)
    !wdt_en |=> !fault_alert)
    else $error("fault while watchdog off");
  chk_wdt_restart: assert property (@(posedge clk) disable iff (!rst_b)
    wdt_en && service_hit |=> state.wdt_cnt == 32'h0)
    else $error("service did not restart");
  chk_wdt_fault: assert property (@(posedge clk) disable iff (!rst_b)
    wdt_en && !sw_write && state.wdt_cnt == 32'(WDT_CYCLES - 1)
    |=> fault_alert)
    else $error("missed service no fault");
  chk_range_map: assert property (@(posedge clk) disable iff (!rst_b)
    output_range_select == 3'h4 |-> range_decoded == DCW_I4_20)
    else $error("range code mismatch");
  chk_range_volt: assert property (@(posedge clk) disable iff (!rst_b)
    output_range_select == 3'h3 |-> range_decoded == DCW_VPM10)
    else $error("voltage range mismatch");
  chk_other_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    word_valid && !sw_write && !boost_write
    |=> $stable(status_toggle) && $stable(boost_cfg))
    else $error("foreign word changed state");
  chk_phase_same: assert property (@(posedge osc_clk) disable iff (!rst_b)
    osc_cfg.phase == 2'h0 |-> boost_switch_clk == 4'h0
                              || boost_switch_clk == 4'hf)
    else $error("phase 00 edges differ");
  cov_reset: cover property (@(posedge clk) disable iff (!rst_b)
    reset_hit);
  cov_service: cover property (@(posedge clk) disable iff (!rst_b)
    wdt_en && service_hit);
  cov_fault: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(fault_alert));
  cov_boost: cover property (@(posedge clk) disable iff (!rst_b)
    boost_write);
endmodule : dcw_decode
`default_nettype wire

// ===== logic/dcw_pkg.sv
// Package for the DAC control word decoder
package dcw_pkg;
  localparam logic [2:0]  SW_ID        = 3'h4;
  localparam logic [2:0]  BOOST_ID     = 3'h3;
  localparam logic [11:0] RESET_CODE   = 12'h555;
  localparam logic [11:0] SERVICE_CODE = 12'h195;
  localparam int          ID_POS       = 13;
  localparam int          TOGGLE_POS   = 12;
  localparam int          COMP_POS     = 6;
  localparam int          PHASE_POS    = 4;
  localparam int          FREQ_POS     = 2;
  localparam int          VLIM_POS     = 0;
  localparam logic        COMP_RST     = 1'h0;
  localparam logic [1:0]  PHASE_RST    = 2'h0;
  localparam logic [1:0]  FREQ_RST     = 2'h1;
  localparam logic [1:0]  VLIM_RST     = 2'h0;
  localparam int          OSC_HZ       = 13000000;
  localparam int          DIV_250K     = OSC_HZ / 250000 / 2;
  localparam int          DIV_410K     = OSC_HZ / 410000 / 2;
  localparam int          DIV_650K     = OSC_HZ / 650000 / 2;
  localparam int          WDT_DEFAULT  = 25000;

  typedef enum logic [2:0] {
    DCW_V0_5, DCW_V0_10, DCW_VPM5, DCW_VPM10,
    DCW_I4_20, DCW_I0_20, DCW_I0_24, DCW_INVALID
  } dcw_range_t;

  typedef struct packed {
    logic       comp;
    logic [1:0] phase;
    logic [1:0] freq;
    logic [1:0] vlim;
  } dcw_boost_t;

  typedef struct packed {
    dcw_boost_t  boost;
    logic        toggle;
    logic [31:0] wdt_cnt;
    logic        fault;
    logic [5:0]  div_cnt;
    logic [3:0]  phase_clk;
  } dcw_state_t;
endpackage : dcw_pkg

// ===== tb/dcw_decode_tb.sv
// Testbench for the control word decoder
`timescale 1ns/100ps
`default_nettype none
module dcw_decode_tb
  import dcw_pkg::*;
;
  logic        clk = 0, osc_clk = 0, rst_b = 0, req = 0, svc_on = 0;
  logic        wdt_enable = 0;
  logic [2:0]  output_range_select = 3'h0;
  logic [15:0] req_word = 16'h0000;
  logic [15:0] word_data;
  logic        word_valid, status_toggle, fault_alert, soft_reset, sr;
  logic [3:0]  boost_switch_clk, last_clk;
  dcw_range_t  range_decoded;
  dcw_boost_t  boost_cfg;
  int          failures = 0, total_checks = 0, n;
  dcw_range_t  exp_rng [2:6] = '{DCW_VPM5, DCW_VPM10, DCW_I4_20,
                                 DCW_I0_20, DCW_I0_24};
  initial forever #20 clk = ~clk;
  initial forever #38.5 osc_clk = ~osc_clk;
  dcw_host #(.SVC_GAP(8)) HOST (.clk(clk), .svc_on(svc_on), .req(req),
    .req_word(req_word), .word_valid(word_valid), .word_data(word_data));
  dcw_decode #(.WDT_CYCLES(20)) DUT (.clk(clk), .rst_b(rst_b),
    .osc_clk(osc_clk), .word_valid(word_valid), .word_data(word_data),
    .output_range_select(output_range_select), .wdt_enable(wdt_enable),
    .range_decoded(range_decoded), .status_toggle(status_toggle),
    .boost_cfg(boost_cfg), .fault_alert(fault_alert),
    .boost_switch_clk(boost_switch_clk), .soft_reset(soft_reset));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [15:0] w);
    @(posedge clk) req <= 1'b1;
    req_word <= w;
    @(negedge clk) #1 sr = soft_reset;
    @(posedge clk) req <= 1'b0;
    @(negedge clk);
  endtask : send
  task automatic conclude;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    chk(16'(boost_cfg), 16'h0004);
    for (int c = 2; c <= 6; c++) begin
      @(negedge clk) output_range_select = 3'(c);
      #1 chk(16'(range_decoded), 16'(exp_rng[c]));
    end
    $display("Test range done");
    send(16'h9123);
    chk(16'(status_toggle), 16'h1);
    send(16'h8123);
    chk(16'(status_toggle), 16'h0);
    send(16'h9123);
    send(16'ha000);
    chk(16'(status_toggle), 16'h1);
    send(16'h1000);
    chk(16'(status_toggle), 16'h1);
    $display("Test toggle done");
    send(16'h7fdb);
    chk(16'(boost_cfg), 16'h005b);
    chk(16'(boost_cfg.vlim), 16'h0003);
    send(16'h6024);
    send(16'he05b);
    chk(16'(boost_cfg), 16'h0024);
    send(16'h6004);
    repeat (20) @(negedge clk);
    n = 0;
    last_clk = boost_switch_clk;
    repeat (200) begin
      @(negedge clk);
      chk(16'(boost_switch_clk == 4'h0 || boost_switch_clk == 4'hf),
          16'h1);
      if (boost_switch_clk !== last_clk) n++;
      last_clk = boost_switch_clk;
    end
    chk(16'(n >= 4 && n <= 9), 16'h1);
    $display("Test boost done");
    send(16'h9555);
    chk(16'(sr), 16'h1);
    chk(16'(status_toggle), 16'h0);
    chk(16'(boost_cfg), 16'h0004);
    $display("Test reset code done");
    wdt_enable = 1'b1;
    @(posedge clk) svc_on <= 1'b1;
    repeat (100) @(negedge clk);
    chk(16'(fault_alert), 16'h0);
    @(posedge clk) svc_on <= 1'b0;
    n = 0;
    while (fault_alert !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n >= 10 && n <= 24), 16'h1);
    if (n == 60) conclude();
    wdt_enable = 1'b0;
    repeat (60) @(negedge clk);
    chk(16'(fault_alert), 16'h0);
    $display("Test watchdog done");
    conclude();
  end
endmodule : dcw_decode_tb
`default_nettype wire

// ===== tb/dcw_host.sv
// Host model that sends control words and services the watchdog
`timescale 1ns/100ps
`default_nettype none
module dcw_host #(
  parameter int SVC_GAP = 8
) (
  input  wire logic        clk,
  input  wire logic        svc_on,
  input  wire logic        req,
  input  wire logic [15:0] req_word,
  output logic             word_valid,
  output logic [15:0]      word_data
);
  int gap = 0;
  initial word_valid = 1'b0;
  initial word_data = 16'h0000;
  // Drive on the falling edge; idle data keeps changing
  always @(negedge clk) begin
    gap <= (gap == SVC_GAP) ? 0 : gap + 1;
    word_valid <= req || (svc_on && gap == SVC_GAP);
    if (req) begin
      word_data <= req_word;
    end else if (svc_on && gap == SVC_GAP) begin
      word_data <= 16'h9195;
    end else begin
      word_data <= ~word_data;
    end
  end
endmodule : dcw_host
`default_nettype wire
